// File: pkg/astx_pkg.sv
// constants, register map and carrier types for the serial transmitter
//==========================================================================
//==========================================================================
package astx_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_TXBUF  = 8'h00; // transmit buffer (write)
  localparam logic [7:0] ADDR_CTRL   = 8'h04; // enable, mode, divisor
  localparam logic [7:0] ADDR_BAUD   = 8'h08; // baud rate control
  localparam logic [7:0] ADDR_STAT   = 8'h0C; // sticky events, w1c
  localparam logic [7:0] ADDR_MASK   = 8'h10; // interrupt mask
  localparam logic [7:0] ADDR_LIVE   = 8'h14; // live flags, read-only
  // control register fields
  localparam int CTRL_TXEN  = 0;
  localparam int CTRL_SYNC  = 1;
  localparam int CTRL_DIV_LO = 16;
  localparam int CTRL_DIV_W = 16;
  localparam logic [15:0] DIV_RESET = 16'h0003; // cycles per bit minus 1
  // baud control fields
  localparam int BAUD_AUTOBAUD_OVERFLOW_FLAG = 7;
  localparam int BAUD_RXIDLE = 6;
  localparam int BAUD_POL    = 4;
  localparam int BAUD_WIDE   = 3;
  localparam int BAUD_WAKE   = 1;
  localparam int BAUD_AUTOBAUD_ENABLE  = 0;
  localparam logic [7:0] BAUD_WMASK = 8'h1B;  // writable bits
  localparam logic [7:0] BAUD_RESET = 8'h40;  // receive idle set
  // status and mask fields
  localparam int EV_EMPTY = 0;  // buffer became empty
  localparam int EV_DONE  = 1;  // stop bit finished
  localparam int EV_W     = 2;
  // frame
  localparam int FRAME_BITS = 10;            // start, 8 data, stop
  localparam logic [3:0] LAST_BIT = 4'h9;
  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // shifter states
  typedef enum logic [1:0] {SH_IDLE, SH_LOAD, SH_SEND} astx_sh_t;
  // signals from the receive and auto-baud side
  typedef struct packed {
    logic rx_idle;     // receiver idle
    logic abd_ovf;     // auto-baud timer overflowed
    logic abd_done;    // auto-baud detection finished
    logic rx_flag;     // receive flag set
  } astx_rxst_t;
endpackage

// File: logic/astx_shift.sv
// frame shifter: serialises one character at a fixed bit period
`timescale 1ns/1ps
module astx_shift (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        LOAD,    // take DATA this cycle
  input  wire logic [7:0]  DATA,    // character to send
  input  wire logic [15:0] DIV,     // cycles per bit minus one
  output logic             BUSY,    // frame under way
  output logic             DONE,    // pulse: stop bit finished
  output logic             LINE     // true-polarity line level
);
  logic [9:0]  frame;     // stop, data lsb first, start
  logic [3:0]  bit_ix;    // bit being sent
  logic [15:0] tick;      // cycles left in this bit
  //========================================================================
  // frame shifting
  //========================================================================
  // a new frame starts on load, start bit first
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      frame  <= 10'h3FF;
      bit_ix <= 4'h0;
      tick   <= 16'h0000;
      BUSY   <= 1'b0;
      DONE   <= 1'b0;
      LINE   <= 1'b1;
    end else begin
      DONE <= 1'b0;
      if (LOAD) begin
        frame  <= {1'b1, DATA, 1'b0};
        LINE   <= 1'b0;          // start bit right after transfer
        bit_ix <= 4'h0;
        tick   <= DIV;
        BUSY   <= 1'b1;
      end else if (BUSY) begin
        if (tick != 16'h0000) begin
          tick <= tick - 16'h0001;
        end else if (bit_ix == astx_pkg::LAST_BIT) begin
          BUSY <= 1'b0;          // stop bit sent, shifter flushed
          DONE <= 1'b1;
          LINE <= 1'b1;          // idle mark
        end else begin
          bit_ix <= bit_ix + 4'h1;
          LINE   <= frame[bit_ix + 4'h1];
          tick   <= DIV;
        end
      end
    end
  end
endmodule // astx_shift

// File: logic/astx_top.sv
// serial transmitter top: axi4-lite registers, holding buffer, shifter
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module astx_top (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // axi4-lite slave
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // receive and auto-baud status
  input  wire astx_pkg::astx_rxst_t RX_STATUS,
  // outputs
  output logic             TX_OUT,
  output logic             WIDE_RATE,
  output logic             AUTOBAUD_EN,
  output logic             WAKE_EN,
  output logic             IRQ
);
  // register state
  logic [31:0] ctrl;                 // enable, mode, divisor
  logic [7:0]  baud_rate_control;    // writable baud bits
  logic [7:0]  transmit_buffer_reg;  // holding buffer
  logic        buf_full;             // character waiting
  logic [astx_pkg::EV_W-1:0] stat;   // sticky events
  logic [astx_pkg::EV_W-1:0] mask;   // interrupt mask
  logic        tx_buffer_empty_flag; // live empty flag
  logic        flag_q;               // previous flag for edge
  // bus capture
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;                // both halves present
  logic        wr_txbuf;             // write hits buffer
  // shifter
  logic        sh_load;
  logic        sh_busy;
  logic        sh_done;
  logic        sh_line;
  logic        txen;
  logic        sync_mode;
  logic [7:0]  baud_view;

  assign txen      = ctrl[astx_pkg::CTRL_TXEN];
  assign sync_mode = ctrl[astx_pkg::CTRL_SYNC];

  //========================================================================
  // write channel
  //========================================================================
  // address and data are taken in either order, one write at a time
  assign AWREADY  = !aw_hold && !BVALID;
  assign WREADY   = !w_hold && !BVALID;
  assign wr_go    = aw_hold && w_hold && !BVALID;
  assign wr_txbuf = wr_go && (aw_addr == astx_pkg::ADDR_TXBUF) && w_strb[0];

  // capture both halves, answer once both are in
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= astx_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_hold <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        BVALID  <= 1'b1;
        // live flag block and unmapped words answer an error
        unique case (aw_addr)
          astx_pkg::ADDR_TXBUF, astx_pkg::ADDR_CTRL, astx_pkg::ADDR_BAUD,
          astx_pkg::ADDR_STAT, astx_pkg::ADDR_MASK:
            BRESP <= astx_pkg::RESP_OKAY;
          default: BRESP <= astx_pkg::RESP_SLVERR;
        endcase
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  //========================================================================
  // control, mask and baud registers
  //========================================================================
  // byte lanes honoured on the control and mask words
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= {astx_pkg::DIV_RESET, 16'h0000};
      mask <= '0;
    end else if (wr_go) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i] && aw_addr == astx_pkg::ADDR_CTRL) begin
          ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
        end
      end
      if (w_strb[0] && aw_addr == astx_pkg::ADDR_MASK) begin
        mask <= w_data[astx_pkg::EV_W-1:0];
      end
    end
  end

  // writable baud bits; enables drop by themselves when hardware is done
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      baud_rate_control <= 8'h00;
    end else begin
      if (wr_go && w_strb[0] && aw_addr == astx_pkg::ADDR_BAUD) begin
        baud_rate_control <= w_data[7:0] & astx_pkg::BAUD_WMASK;
      end
      if (RX_STATUS.abd_done) begin
        baud_rate_control[astx_pkg::BAUD_AUTOBAUD_ENABLE] <= 1'b0;
      end
      if (RX_STATUS.rx_flag) begin
        baud_rate_control[astx_pkg::BAUD_WAKE] <= 1'b0;
      end
    end
  end

  // read-only status bits come live from the receive side, overflow only in asynchronous mode
  always_comb begin
    baud_view = baud_rate_control;
    baud_view[astx_pkg::BAUD_AUTOBAUD_OVERFLOW_FLAG] = RX_STATUS.abd_ovf && !sync_mode;
    baud_view[astx_pkg::BAUD_RXIDLE] = RX_STATUS.rx_idle;
  end

  assign WIDE_RATE   = baud_rate_control[astx_pkg::BAUD_WIDE];
  assign AUTOBAUD_EN = baud_rate_control[astx_pkg::BAUD_AUTOBAUD_ENABLE];
  assign WAKE_EN     = baud_rate_control[astx_pkg::BAUD_WAKE];

  //========================================================================
  // holding buffer and shifter hand-off
  //========================================================================
  // idle shifter loads on the cycle after the write a busy one
  // keeps the byte queued until its stop bit ends
  assign sh_load = buf_full && txen && !sh_busy;

  // a write while full overwrites the queued byte, as software was told
  // to wait for the empty flag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      transmit_buffer_reg <= 8'h00;
      buf_full            <= 1'b0;
    end else begin
      if (wr_txbuf) begin
        transmit_buffer_reg <= w_data[7:0];
        buf_full            <= 1'b1;
      end else if (sh_load) begin
        buf_full <= 1'b0;
      end
    end
  end

  astx_shift u_shift (
    .CLK    (CLK),
    .ARST_N (ARST_N),
    .LOAD   (sh_load),
    .DATA   (transmit_buffer_reg),
    .DIV    (ctrl[astx_pkg::CTRL_DIV_LO +: astx_pkg::CTRL_DIV_W]),
    .BUSY   (sh_busy),
    .DONE   (sh_done),
    .LINE   (sh_line)
  );

  // inversion only in asynchronous mode; in synchronous mode this bit
  // belongs to clock polarity, which this block does not drive
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_OUT <= 1'b1;                              // idle mark
    end else if (!sync_mode && baud_rate_control[astx_pkg::BAUD_POL]) begin
      TX_OUT <= !sh_line;
    end else begin
      TX_OUT <= sh_line;
    end
  end

  //========================================================================
  // empty flag and interrupt
  //========================================================================
  // flag follows buffer state, registered so it settles two cycles after
  // the write is taken; bus writes never touch it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_buffer_empty_flag <= 1'b0;
      flag_q               <= 1'b0;
    end else begin
      // low while transmit is disabled or a byte waits behind a busy shifter, so an idle
      // shifter taking a fresh byte never shows a false empty dip
      tx_buffer_empty_flag <= txen && !(buf_full && sh_busy);
      flag_q               <= tx_buffer_empty_flag;
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stat <= '0;
    end else begin
      if (wr_go && w_strb[0] && aw_addr == astx_pkg::ADDR_STAT) begin
        stat <= stat & ~w_data[astx_pkg::EV_W-1:0];
      end
      if (tx_buffer_empty_flag && !flag_q) begin
        stat[astx_pkg::EV_EMPTY] <= 1'b1;
      end
      if (sh_done) begin
        stat[astx_pkg::EV_DONE] <= 1'b1;
      end
    end
  end

  // mask gates only the interrupt, never the flag
  assign IRQ = |(stat & mask);

  //========================================================================
  // read channel
  //========================================================================
  assign ARREADY = !RVALID;

  // read data registered, one cycle after the address is taken
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= astx_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP  <= astx_pkg::RESP_OKAY;
      unique case (ARADDR)
        astx_pkg::ADDR_TXBUF: RDATA <= {24'h000000, transmit_buffer_reg};
        astx_pkg::ADDR_CTRL:  RDATA <= ctrl;
        astx_pkg::ADDR_BAUD:  RDATA <= {24'h000000, baud_view};
        astx_pkg::ADDR_STAT:  RDATA <= {30'h0, stat};
        astx_pkg::ADDR_MASK:  RDATA <= {30'h0, mask};
        astx_pkg::ADDR_LIVE:
          RDATA <= {29'h0, buf_full, sh_busy, tx_buffer_empty_flag};
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= astx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end
endmodule // astx_top

// File: tb/astx_monitor.sv
// checker: write handshake, line timing and baud control outputs
`timescale 1ns/1ps
module astx_monitor (
  input wire logic                 CLK,
  input wire logic                 ARST_N,
  input wire logic [7:0]           AWADDR,
  input wire logic                 AWVALID,
  input wire logic                 AWREADY,
  input wire logic [31:0]          WDATA,
  input wire logic                 WVALID,
  input wire logic                 WREADY,
  input wire logic [1:0]           BRESP,
  input wire logic                 BVALID,
  input wire astx_pkg::astx_rxst_t RX_STATUS,
  input wire logic                 TX_OUT,
  input wire logic                 WIDE_RATE,
  input wire logic                 AUTOBAUD_EN,
  input wire logic                 WAKE_EN,
  input wire logic                 IRQ
);
  logic [7:0]  wa; // address of the last write taken
  logic [31:0] wd; // data of the last write taken
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  //==========================================================================
  // write capture
  // kept so a response seen later can be judged against its request
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) wa <= 8'h00;
    else if (AWVALID && AWREADY) wa <= AWADDR;
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) wd <= 32'h0;
    else if (WVALID && WREADY) wd <= WDATA;
  end
  //==========================================================================
  // assertions
  chk_idle_reset: assert property ($rose(ARST_N) |-> TX_OUT)
    else $error("line not idle high after reset");
  // with the reset divisor every level lasts at least four cycles
  chk_bit_hold: assert property ($changed(TX_OUT) |=> $stable(TX_OUT)[*3])
    else $error("line level shorter than one bit");
  chk_write_answer: assert property
    (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write answer late");
  chk_write_block: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while answer pending");
  chk_ro_slverr: assert property ($rose(BVALID) &&
    wa >= astx_pkg::ADDR_LIVE |-> BRESP == astx_pkg::RESP_SLVERR)
    else $error("read-only or unmapped write not refused");
  chk_wide_track: assert property ($rose(BVALID) &&
    wa == astx_pkg::ADDR_BAUD |=> WIDE_RATE == wd[astx_pkg::BAUD_WIDE])
    else $error("generator width select not following register");
  chk_abd_clear: assert property
    (AUTOBAUD_EN && RX_STATUS.abd_done |-> ##[1:2] !AUTOBAUD_EN)
    else $error("auto-baud enable not cleared");
  chk_wake_clear: assert property
    (WAKE_EN && RX_STATUS.rx_flag |-> ##[1:2] !WAKE_EN)
    else $error("wake enable not cleared");
  chk_irq_gate: assert property ($rose(BVALID) &&
    wa == astx_pkg::ADDR_MASK && wd[2:0] == 3'h0 |=> !IRQ)
    else $error("interrupt high with mask cleared");
  cov_frame: cover property ($fell(TX_OUT));
  cov_irq: cover property ($fell(IRQ));
  cov_abd: cover property ($fell(AUTOBAUD_EN));
endmodule // astx_monitor

bind astx_top astx_monitor i_mon (.CLK(CLK), .ARST_N(ARST_N),
  .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
  .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .RX_STATUS(RX_STATUS), .TX_OUT(TX_OUT), .WIDE_RATE(WIDE_RATE),
  .AUTOBAUD_EN(AUTOBAUD_EN), .WAKE_EN(WAKE_EN), .IRQ(IRQ));

// File: tb/astx_rx_model.sv
// remote receiver model: samples the serial line at mid-bit
`timescale 1ns/1ps
module astx_rx_model #(
  parameter int BIT_CYC = 4 // cycles per bit
) (
  input  wire logic  clk,
  input  wire logic  line,
  input  wire logic  inv,     // line inverted
  input  wire logic  en,      // opens frames only while set
  output logic       got,     // pulse: character taken
  output logic [7:0] rx_byte,
  output logic       ok,      // stop bit seen at mark level
  output int         gap      // cycles since previous start
);
  int         t  = 0; // free cycle count
  int         t0 = 0; // cycle of previous start
  logic [7:0] v;      // character under assembly
  always @(posedge clk) t <= t + 1;
  //==========================================================================
  // frame reception
  initial begin
    got = 1'b0;
    rx_byte = 8'h00;
    ok = 1'b0;
    gap = 0;
    forever begin
      @(posedge clk);
      // a space level while listening opens a frame
      if (en && (line ^ inv) === 1'b0) begin
        gap <= t - t0;
        t0 = t;
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clk);
          v[i] = line ^ inv; // least significant bit first
        end
        repeat (BIT_CYC) @(posedge clk);
        ok <= (line ^ inv) === 1'b1;
        rx_byte <= v;
        got <= 1'b1;
        @(posedge clk);
        got <= 1'b0;
      end
    end
  end
endmodule // astx_rx_model

// File: tb/astx_top_tb_top.sv
// self-checking bench for the serial transmitter top
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module astx_top_tb_top;
  localparam logic [7:0] TXB = astx_pkg::ADDR_TXBUF;
  localparam logic [7:0] CTRL = astx_pkg::ADDR_CTRL;
  localparam logic [7:0] BAUD = astx_pkg::ADDR_BAUD;
  localparam logic [7:0] STAT = astx_pkg::ADDR_STAT;
  localparam logic [7:0] MASK = astx_pkg::ADDR_MASK;
  localparam logic [7:0] LIVE = astx_pkg::ADDR_LIVE;
  localparam logic [1:0] ER = astx_pkg::RESP_SLVERR;
  logic        CLK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_OUT, IRQ;
  logic        WIDE_RATE, AUTOBAUD_EN, WAKE_EN, got, en, inv, ok;
  logic [7:0]  AWADDR, ARADDR, rx_byte, b;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [65:0] rq[$], e; // read notes: response, mask, value
  logic [1:0]  bq[$];    // write response notes
  logic [8:0]  sq[$], s; // serial notes: back to back, character
  int          n_fail, num_checks, cyc, gap;
  astx_pkg::astx_rxst_t rxs; // receive side status levels
  astx_top i_dut (.CLK(CLK), .ARST_N(ARST_N), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .RX_STATUS(rxs), .TX_OUT(TX_OUT), .WIDE_RATE(WIDE_RATE),
    .AUTOBAUD_EN(AUTOBAUD_EN), .WAKE_EN(WAKE_EN), .IRQ(IRQ));
  astx_rx_model #(.BIT_CYC(int'(astx_pkg::DIV_RESET) + 1)) i_rx (
    .clk(CLK), .line(TX_OUT), .inv(inv), .en(en), .got(got),
    .rx_byte(rx_byte), .ok(ok), .gap(gap));
  //==========================================================================
  // clock and timeout
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // whole run is under a thousand cycles; triple that is a hang
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  //==========================================================================
  // bus tasks: the caller notes what the watcher must see
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = astx_pkg::RESP_OKAY);
    bq.push_back(r);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] r = astx_pkg::RESP_OKAY);
    rq.push_back({r, m, v});
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
  endtask
  // random character into the buffer, noted for the receiver
  task automatic send(input logic q);
    b = 8'($urandom);
    sq.push_back({q, b});
    wr(TXB, {24'h0, b});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //==========================================================================
  // watcher: oldest note against each result as it appears
  always @(posedge CLK) begin
    if (RVALID && RREADY) begin
      e = rq.pop_front();
      `CHK(RDATA & e[63:32], e[31:0]);
      `CHK(RRESP, e[65:64]);
    end
    if (BVALID && BREADY) `CHK(BRESP, bq.pop_front());
    if (got) begin
      s = sq.pop_front();
      `CHK({ok, rx_byte}, {1'b1, s[7:0]});
      if (s[8]) `CHK(gap inside {[40:42]}, 1'b1);
    end
  end
  //==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'hA351EB4D));
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    WSTRB = 4'hF;
    rxs = 4'h8; // receiver idle
    en = 1'b0;
    inv = 1'b0;
    ARST_N = 1'b0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(BAUD, 32'h40);
    rd(CTRL, 32'h00030000);
    rd(LIVE, 32'h0);
    wr(CTRL, 32'h00030001);
    rd(LIVE, 32'h1);
    rd(STAT, 32'h1, 32'h1);
    wr(MASK, 32'h1);
    #1 `CHK(IRQ, 1'b1);
    wr(STAT, 32'h1);
    #1 `CHK(IRQ, 1'b0);
    wr(LIVE, 32'h0, ER);
    rd(LIVE, 32'h1, 32'h1);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, ER);
    // second character queued behind the first
    en = 1'b1;
    send(1'b0);
    repeat (2) @(posedge CLK);
    #1 `CHK(TX_OUT, 1'b0);
    send(1'b1);
    wr(MASK, 32'h0);
    @(posedge CLK);
    rd(LIVE, 32'h6, 32'h7);
    repeat (36) @(posedge CLK);
    rd(LIVE, 32'h3, 32'h7);
    repeat (45) @(posedge CLK);
    rd(STAT, 32'h3, 32'h3);
    // inverted line, then synchronous mode drops the inversion
    en = 1'b0;
    wr(BAUD, 32'h10);
    #1 `CHK(TX_OUT, 1'b0);
    rd(BAUD, 32'h50);
    inv = 1'b1;
    en = 1'b1;
    send(1'b0);
    repeat (2) @(posedge CLK);
    #1 `CHK(TX_OUT, 1'b1);
    repeat (45) @(posedge CLK);
    en = 1'b0;
    wr(CTRL, 32'h00030003);
    #1 `CHK(TX_OUT, 1'b1);
    repeat (4) @(posedge CLK);
    wr(CTRL, 32'h00030001);
    repeat (4) @(posedge CLK);
    // baud control enables and their self-clearing
    wr(BAUD, 32'h0B);
    rd(BAUD, 32'h4B);
    #1 `CHK({WIDE_RATE, WAKE_EN, AUTOBAUD_EN}, 3'b111);
    @(posedge CLK) rxs.abd_done <= 1'b1;
    @(posedge CLK) rxs.abd_done <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 `CHK(AUTOBAUD_EN, 1'b0);
    @(posedge CLK) rxs.rx_flag <= 1'b1;
    @(posedge CLK) rxs.rx_flag <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 `CHK(WAKE_EN, 1'b0);
    @(posedge CLK) rxs <= 4'h4; // overflow, receiver busy
    rd(BAUD, 32'h80, 32'hC0);
    repeat (4) @(posedge CLK);
    conclude();
  end
endmodule // astx_top_tb_top
